// ==== logic/dwcs_top.sv ====
// Dual wiper code store top: two independent channels and power-up recall
// Summary of operation
// [R1] Each channel's tap comes only from its own 8-bit wiper code.
// [R2] Code zero selects tap nearest lower end, all ones nearest upper end.
// [R3] Increasing code moves the tap monotonically toward the upper end.
// [R4] 256 distinct taps per channel, fraction is code over 256.
// [R5] At power-up each preset is copied into its wiper code.
// [R6] Preset keeps the last value written across power-down; ARST_N reloads it with 0x80 instead.
// [R7] Preset holds factory value 0x80 before any programming.
// [R8] Stored-write select decides whether a write also updates the preset.
// [R9] Code-only write moves wiper at once and leaves the preset alone.
// [R10] Both channels independent: own code, preset and shutdown.
// [R11] Shutdown opens the upper end switch, terminal H high impedance.
// [R12] Leaving shutdown reconnects H within 800 ns of control byte end.
// [R13] Preset recall done and standby reached within 100 us of power-up.
// [R14] Wiper writes ignored until the power-up recall has finished.
`include "dwcs_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module dwcs_top (
   input  wire logic        CORE_CLK,
   input  wire logic        ARST_N,
   input  wire logic        WR_EN,
   input  wire logic        WR_CH,
   input  wire logic [7:0]  WR_DATA,
   input  wire logic        CTRL_STB,
   input  wire logic        STORED_WRITE_SELECT,
   input  wire logic [1:0]  SHUTDOWN_REQ,
   output logic [7:0]       CODE_A,
   output logic [7:0]       CODE_B,
   output logic [7:0]       PRESET_A,
   output logic [7:0]       PRESET_B,
   output logic [255:0]     TAP_A,
   output logic [255:0]     TAP_B,
   output logic [1:0]       H_CONNECT,
   output logic             READY
);
   logic       recall_stb;
   logic       ready;
   logic       wr_ok;
   logic [1:0] wen;
   logic [1:0] stored_sel_r;

   // Power-up recall sequencer
   dwcs_powerup u_pwr (
      .clk        (CORE_CLK),
      .arst_n     (ARST_N),
      .recall_stb (recall_stb),
      .ready      (ready)
   );

   // Access control: one stored-write select latched for both channels on control strobe
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         stored_sel_r <= 2'b00;
      end else if (CTRL_STB) begin
         stored_sel_r <= {2{STORED_WRITE_SELECT}}; // R8
      end
   end

   // Writes gated until recall is complete
   assign wr_ok = WR_EN && ready; // R14
   assign wen   = {wr_ok && (WR_CH == `DWCS_CH_B), wr_ok && (WR_CH == `DWCS_CH_A)}; // R10

   // Channel A
   dwcs_channel u_ch_a (
      .clk          (CORE_CLK),
      .arst_n       (ARST_N),
      .recall_stb   (recall_stb),
      .write_en     (wen[0]),
      .stored_sel   (stored_sel_r[0]),
      .wdata        (WR_DATA),
      .shutdown_req (SHUTDOWN_REQ[0]),
      .ctrl_stb     (CTRL_STB),
      .code         (CODE_A),
      .preset       (PRESET_A),
      .h_connect    (H_CONNECT[0]),
      .tap_sel      (TAP_A)
   );

   // Channel B
   dwcs_channel u_ch_b (
      .clk          (CORE_CLK),
      .arst_n       (ARST_N),
      .recall_stb   (recall_stb),
      .write_en     (wen[1]),
      .stored_sel   (stored_sel_r[1]),
      .wdata        (WR_DATA),
      .shutdown_req (SHUTDOWN_REQ[1]),
      .ctrl_stb     (CTRL_STB),
      .code         (CODE_B),
      .preset       (PRESET_B),
      .h_connect    (H_CONNECT[1]),
      .tap_sel      (TAP_B)
   );

   assign READY = ready;

   a_write_block: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      (WR_EN && !ready && !recall_stb) |=> $stable(CODE_A) && $stable(CODE_B))
      else $error("write accepted before recall done"); // R14
   a_ch_indep: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      (wen[0] && !recall_stb) |=> $stable(CODE_B)) else $error("channel B disturbed by A write"); // R10
   a_recall_load: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      recall_stb |=> (CODE_A == $past(PRESET_A)) && (CODE_B == $past(PRESET_B)))
      else $error("preset not recalled"); // R5
endmodule
`default_nettype wire

// ==== logic/dwcs_consts.svh ====
// Constants for the dual wiper code store
`ifndef DWCS_CONSTS_SVH
`define DWCS_CONSTS_SVH
`define DWCS_CODE_W         8
`define DWCS_PRESET_FACTORY 8'h80
`define DWCS_CODE_ZERO      8'h00
`define DWCS_CH_A           1'b0
`define DWCS_CH_B           1'b1
`define DWCS_CLK_PERIOD_PS  5000
`define DWCS_SR_TIME_NS     800
`define DWCS_SR_CYCLES      ((`DWCS_SR_TIME_NS * 1000) / `DWCS_CLK_PERIOD_PS)
`define DWCS_PU_TIME_US     100
`define DWCS_PU_CYCLES      ((`DWCS_PU_TIME_US * 1000000) / `DWCS_CLK_PERIOD_PS)
`define DWCS_RECALL_CYCLES  4
`endif

// ==== logic/dwcs_pkg.sv ====
// Types for the dual wiper code store
package dwcs_pkg;
   typedef logic [7:0] dwcs_code_t;
   typedef enum logic [2:0] {
      DWCS_RECALL  = 3'b001,
      DWCS_WAIT    = 3'b010,
      DWCS_STANDBY = 3'b100
   } dwcs_pwr_e;
endpackage

// ==== logic/dwcs_channel.sv ====
// One wiper channel: wiper code, preset store and shutdown switch
`include "dwcs_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module dwcs_channel #(
   parameter int SR_CYCLES = `DWCS_SR_CYCLES
) (
   input  wire logic              clk,
   input  wire logic              arst_n,
   input  wire logic              recall_stb,
   input  wire logic              write_en,
   input  wire logic              stored_sel,
   input  wire logic [7:0]        wdata,
   input  wire logic              shutdown_req,
   input  wire logic              ctrl_stb,
   output var  dwcs_pkg::dwcs_code_t code,
   output var  dwcs_pkg::dwcs_code_t preset,
   output logic                   h_connect,
   output logic [255:0]           tap_sel
);
   dwcs_pkg::dwcs_code_t code_r;
   dwcs_pkg::dwcs_code_t preset_r;
   logic                 shut_r;
   logic                 conn_r;
   logic [9:0]           sr_cnt_r;

   // Preset store: keeps value, factory reset value
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         preset_r <= `DWCS_PRESET_FACTORY; // R7
      end else if (write_en && stored_sel) begin
         preset_r <= wdata; // R6
      end
   end

   // Wiper code: recall at power-up, host write moves wiper immediately
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         code_r <= `DWCS_CODE_ZERO;
      end else if (recall_stb) begin
         code_r <= preset_r; // R5
      end else if (write_en) begin
         code_r <= wdata; // R8 R9
      end
   end

   // Shutdown state and upper terminal reconnect timer
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         shut_r   <= 1'b0;
         conn_r   <= 1'b1;
         sr_cnt_r <= '0;
      end else begin
         if (ctrl_stb) begin
            shut_r <= shutdown_req;
         end
         if (ctrl_stb && shutdown_req) begin
            conn_r   <= 1'b0; // R11
            sr_cnt_r <= '0;
         end else if (!conn_r && !shut_r) begin
            if (sr_cnt_r >= 10'(SR_CYCLES - 1)) begin
               conn_r <= 1'b1; // R12
            end else begin
               sr_cnt_r <= sr_cnt_r + 10'd1;
            end
         end
      end
   end

   // One-hot tap select decoded only from the code
   always_comb begin
      tap_sel = '0;
      tap_sel[code_r] = 1'b1; // R1 R2 R3 R4
   end

   assign code      = code_r;
   assign preset    = preset_r;
   assign h_connect = conn_r;

   a_tap_onehot: assert property (@(posedge clk) disable iff (!arst_n)
      tap_sel[code_r] && $onehot(tap_sel)) else $error("tap select not one-hot of code"); // R4
   a_vol_write: assert property (@(posedge clk) disable iff (!arst_n)
      (write_en && !stored_sel && !recall_stb) |=> (code_r == $past(wdata)) && $stable(preset_r))
      else $error("volatile write wrong"); // R9
   a_shut_open: assert property (@(posedge clk) disable iff (!arst_n)
      (ctrl_stb && shutdown_req) |=> !conn_r) else $error("shutdown did not open H"); // R11
   a_shut_leave: assert property (@(posedge clk) disable iff (!arst_n)
      (ctrl_stb && !shutdown_req && !conn_r) |-> ##[1:161] conn_r) else $error("H not reconnected"); // R12
endmodule
`default_nettype wire

// ==== logic/dwcs_powerup.sv ====
// Power-up sequencer: preset recall then serial standby
`include "dwcs_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module dwcs_powerup #(
   parameter int PU_CYCLES = `DWCS_PU_CYCLES
) (
   input  wire logic clk,
   input  wire logic arst_n,
   output logic      recall_stb,
   output logic      ready
);
   dwcs_pkg::dwcs_pwr_e st_r;
   logic [15:0]         cnt_r;
   logic [15:0]         pu_age_r;

   // Cycles spent since reset release without reaching standby
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pu_age_r <= '0;
      end else if (!ready) begin
         pu_age_r <= pu_age_r + 16'd1; // R13
      end
   end

   // Recall strobe, then settle, then standby
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r  <= dwcs_pkg::DWCS_RECALL;
         cnt_r <= '0;
      end else begin
         case (st_r)
            dwcs_pkg::DWCS_RECALL: begin
               st_r  <= dwcs_pkg::DWCS_WAIT; // R5
               cnt_r <= '0;
            end
            dwcs_pkg::DWCS_WAIT: begin
               cnt_r <= cnt_r + 16'd1;
               if (cnt_r >= 16'(`DWCS_RECALL_CYCLES - 1)) begin
                  st_r <= dwcs_pkg::DWCS_STANDBY; // R13
               end
            end
            dwcs_pkg::DWCS_STANDBY: st_r <= dwcs_pkg::DWCS_STANDBY;
            default: st_r <= dwcs_pkg::DWCS_RECALL;
         endcase
      end
   end

   assign recall_stb = (st_r == dwcs_pkg::DWCS_RECALL);
   assign ready      = (st_r == dwcs_pkg::DWCS_STANDBY);

   a_pu_bound: assert property (@(posedge clk) disable iff (!arst_n)
      recall_stb |-> ##[1:8] ready) else $error("standby not reached in time"); // R13
   a_limit_ok: assert property (@(posedge clk) disable iff (!arst_n)
      !ready |-> (pu_age_r < 16'(PU_CYCLES))) else $error("recall exceeds power-up limit"); // R13
endmodule
`default_nettype wire

// ==== bench/dwcs_host_model.sv ====
// Host controller model: wiper writes and access-control strobes
`timescale 1ns/1ps
`default_nettype none
module dwcs_host_model (
   input  wire logic       clk,
   output logic            wr_en,
   output logic            wr_ch,
   output logic [7:0]      wr_data,
   output logic            ctrl_stb,
   output logic            stored_sel,
   output logic [1:0]      shutdown_req
);
   // Idle bus at time zero
   initial begin
      wr_en = 1'b0;
      wr_ch = 1'b0;
      wr_data = 8'h00;
      ctrl_stb = 1'b0;
      stored_sel = 1'b0;
      shutdown_req = 2'b00;
   end

   // Wiper write: one-cycle strobe, data scrambled once released
   task automatic wr(input logic ch, input logic [7:0] data);
      @(posedge clk);
      wr_en   <= 1'b1;
      wr_ch   <= ch;
      wr_data <= data;
      @(posedge clk);
      wr_en   <= 1'b0;
      wr_ch   <= ~ch;
      wr_data <= ~data;
   endtask

   // Access-control byte done: stored-write select and shutdown bits
   task automatic ctrl(input logic sel, input logic [1:0] sd);
      @(posedge clk);
      ctrl_stb     <= 1'b1;
      stored_sel   <= sel;
      shutdown_req <= sd;
      @(posedge clk);
      ctrl_stb     <= 1'b0;
      stored_sel   <= ~sel;
      shutdown_req <= ~sd;
   endtask
endmodule
`default_nettype wire

// ==== bench/dwcs_top_bench.sv ====
// Self-checking bench for the dual wiper code store
`timescale 1ns/1ps
`default_nettype none
module dwcs_top_bench;
   logic         clk = 1'b0;
   logic         arst_n;
   logic         wr_en, wr_ch, ctrl_stb, stored_sel, ready;
   logic [7:0]   wr_data, code_a, code_b, preset_a, preset_b;
   logic [1:0]   shutdown_req, h_connect;
   logic [255:0] tap_a, tap_b;
   int           checks = 0;
   int           bad_count = 0;
   int           cycles = 0;
   int           n;

   // Clock and hang guard
   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         summarize();
      end
   end

   dwcs_host_model host (.clk(clk), .wr_en(wr_en), .wr_ch(wr_ch), .wr_data(wr_data),
      .ctrl_stb(ctrl_stb), .stored_sel(stored_sel), .shutdown_req(shutdown_req));

   dwcs_top dut (.CORE_CLK(clk), .ARST_N(arst_n), .WR_EN(wr_en), .WR_CH(wr_ch),
      .WR_DATA(wr_data), .CTRL_STB(ctrl_stb), .STORED_WRITE_SELECT(stored_sel),
      .SHUTDOWN_REQ(shutdown_req), .CODE_A(code_a), .CODE_B(code_b), .PRESET_A(preset_a),
      .PRESET_B(preset_b), .TAP_A(tap_a), .TAP_B(tap_b), .H_CONNECT(h_connect), .READY(ready));

   // Compare and count
   task automatic chk(input logic [255:0] got, input logic [255:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Counts and verdict
   task automatic summarize;
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial begin
      arst_n = 1'b0;
      repeat (5) @(posedge clk);
      @(negedge clk);
      chk(preset_a, 8'h80);
      chk(preset_b, 8'h80);
      chk(h_connect, 2'b11);
      @(posedge clk);
      arst_n <= 1'b1;
      host.wr(1'b0, 8'h11);
      for (n = 0; n < 100 && ready !== 1'b1; n++) @(negedge clk);
      chk(ready, 1'b1);
      chk(code_a, 8'h80);
      chk(code_b, 8'h80);
      // Every code of channel A selects its own single tap
      for (int i = 0; i < 256; i++) begin
         host.wr(1'b0, i[7:0]);
         @(negedge clk);
         chk(tap_a, 256'h1 << i);
      end
      chk(tap_b, 256'h1 << 8'h80);
      chk(preset_a, 8'h80);
      // Stored write then code-only write on channel B
      host.ctrl(1'b1, 2'b00);
      host.wr(1'b1, 8'h3C);
      @(negedge clk);
      chk(preset_b, 8'h3C);
      chk(code_b, 8'h3C);
      chk(preset_a, 8'h80);
      host.ctrl(1'b0, 2'b00);
      host.wr(1'b1, 8'h05);
      @(negedge clk);
      chk(code_b, 8'h05);
      chk(preset_b, 8'h3C);
      // Shutdown of A alone, then both, then release
      host.ctrl(1'b0, 2'b01);
      @(negedge clk);
      chk(h_connect, 2'b10);
      chk(code_a, 8'hFF);
      host.ctrl(1'b0, 2'b11);
      @(negedge clk);
      chk(h_connect, 2'b00);
      // Reconnect lands on the 160th edge after the strobe: 161 half-cycle-late looks
      host.ctrl(1'b0, 2'b00);
      for (n = 0; n < 161 && h_connect !== 2'b11; n++) @(negedge clk);
      chk(h_connect, 2'b11);
      chk(tap_a, 256'h1 << 8'hFF);
      summarize();
   end
endmodule
`default_nettype wire
